/* verilog/func_status_query.sv */
// What this block does
// - selector picks status content; 000b-101b valid, 110b and 111b reserved
// - device drives a 16-bit status word chosen by selector and function
// - completion is high one cycle for each request cycle, as values are presented
// - request with valid index loads that function's outputs and completes in the same cycle
// - selector 0 bit 0 is io enable; endpoint turns io requests away as UR
// - selector 0 bit 1 is memory enable; endpoint turns memory requests away
// - selector 0 bit 3 is interrupt inhibit; legacy interrupts blocked while set
// - selector 0 bits 3:0 mirror command bits 0, 1, 2 and 10
// - selector 0 bit 4 is the command system error reporting enable
// - selector 0 bit 7 shows end-to-end crc generation enabled
// - selector 1 bit 0 is correctable error detected, logged regardless
`include "func_status_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module func_status_query #(
  parameter int NUM_FUNC = 8,
  parameter bit IS_ENDPOINT = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // register port
  input wire logic [`FS_ADDR_W-1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  // status query port
  input wire func_status_pkg::status_sel_t i_status_sel,
  input wire logic [2:0] i_func_num,
  input wire logic i_out_req,
  output logic [15:0] o_status_data,
  output logic o_update_done,
  // per-function outputs of the selected function
  output logic o_io_enable,
  output logic o_mem_enable,
  output logic o_bus_master_enable,
  output logic o_intx_disable,
  output logic o_serr_enable,
  output logic o_ecrc_gen_enable,
  // correctable error event from the link side
  input wire logic i_corr_err_evt,
  input wire logic [2:0] i_corr_err_func,
  // incoming request filter
  input wire logic i_rx_valid,
  input wire func_status_pkg::rx_kind_t i_rx_kind,
  input wire logic [2:0] i_rx_func,
  output logic o_rx_accept,
  output logic o_rx_unsupported,
  // legacy interrupt gate
  input wire logic i_intx_req,
  input wire logic [2:0] i_intx_func,
  output logic o_intx_assert
);
  import func_status_pkg::*;

  logic [15:0] cmd_r [NUM_FUNC];
  logic [15:0] aer_r [NUM_FUNC];
  logic [15:0] bridge_r [NUM_FUNC];
  logic [NUM_FUNC-1:0] corr_r;
  logic [2:0] func_r;
  status_sel_t sel_r;
  logic [2:0] wfunc;
  logic [1:0] wreg;

  assign wfunc = i_reg_addr[4:2];
  assign wreg = i_reg_addr[1:0];

  // build the status word for one function and selector
  function automatic logic [15:0] status_word(input status_sel_t sel,
                                              input logic [15:0] cmd,
                                              input logic [15:0] aer,
                                              input logic [15:0] bridge,
                                              input logic corr);
    logic [15:0] w;
    w = 16'h0000; // upper slice and unused selectors stay zero
    unique case (sel)
      SEL_COMMAND: begin
        w[`FS_S0_IO] = cmd[`FS_CMD_IO_BIT];
        w[`FS_S0_MEM] = cmd[`FS_CMD_MEM_BIT];
        w[`FS_S0_BME] = cmd[`FS_CMD_BME_BIT];
        w[`FS_S0_INTDIS] = cmd[`FS_CMD_INTDIS_BIT];
        w[`FS_S0_SERR] = cmd[`FS_CMD_SERR_BIT];
        w[`FS_S0_BSERR] = bridge[`FS_BRIDGE_SERR_BIT];
        w[`FS_S0_ECRC_CHK] = aer[`FS_AER_ECRC_CHK_BIT];
        w[`FS_S0_ECRC_GEN] = aer[`FS_AER_ECRC_GEN_BIT];
      end
      SEL_DEV_STATUS: begin
        w[`FS_S1_CORR] = corr;
      end
      SEL_2, SEL_3, SEL_4, SEL_5: begin
        w = 16'h0000; // field maps not carried by this block
      end
      default: begin
        w = 16'h0000; // reserved selector codes read as zero
      end
    endcase
    return w;
  endfunction

  // per-function command, aer and bridge control registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int f = 0; f < NUM_FUNC; f++) begin
        cmd_r[f] <= `FS_CMD_RST;
        aer_r[f] <= `FS_AER_RST;
        bridge_r[f] <= `FS_BRIDGE_RST;
      end
    end else if (i_reg_wr) begin
      unique case (wreg)
        `FS_REG_CMD: cmd_r[wfunc] <= i_reg_wdata;
        `FS_REG_AER: aer_r[wfunc] <= i_reg_wdata;
        `FS_REG_BRIDGE: bridge_r[wfunc] <= i_reg_wdata;
        `FS_REG_DEVSTS: ;
      endcase
    end
  end

  // sticky correctable error flags, write one to clear, set wins
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      corr_r <= {NUM_FUNC{`FS_DEVSTS_RST}};
    end else begin
      for (int f = 0; f < NUM_FUNC; f++) begin
        if (i_corr_err_evt && i_corr_err_func == 3'(f)) begin
          corr_r[f] <= 1'b1; // logged whatever reporting says
        end else if (i_reg_wr && wreg == `FS_REG_DEVSTS && wfunc == 3'(f)
                     && i_reg_wdata[`FS_DEVSTS_CORR_BIT]) begin
          corr_r[f] <= 1'b0;
        end
      end
    end
  end

  // read data one cycle after the read strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      unique case (wreg)
        `FS_REG_CMD: o_reg_rdata <= cmd_r[wfunc];
        `FS_REG_AER: o_reg_rdata <= aer_r[wfunc];
        `FS_REG_BRIDGE: o_reg_rdata <= bridge_r[wfunc];
        `FS_REG_DEVSTS: o_reg_rdata <= {15'h0000, corr_r[wfunc]};
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

  // latch the requested function and track the selector
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      func_r <= 3'h0;
      sel_r <= SEL_COMMAND;
    end else begin
      sel_r <= i_status_sel;
      if (i_out_req) begin
        func_r <= i_func_num; // index 0-1 physical, 2-7 virtual
      end
    end
  end

  // status word refreshed on request or selector change, else held
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status_data <= 16'h0000;
    end else if (i_out_req) begin
      o_status_data <= status_word(i_status_sel, cmd_r[i_func_num], aer_r[i_func_num],
                                   bridge_r[i_func_num], corr_r[i_func_num]);
    end else if (i_status_sel != sel_r) begin
      o_status_data <= status_word(i_status_sel, cmd_r[func_r], aer_r[func_r],
                                   bridge_r[func_r], corr_r[func_r]);
    end
  end

  // per-function outputs loaded with the word, done in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_io_enable <= 1'b0;
      o_mem_enable <= 1'b0;
      o_bus_master_enable <= 1'b0;
      o_intx_disable <= 1'b0;
      o_serr_enable <= 1'b0;
      o_ecrc_gen_enable <= 1'b0;
      o_update_done <= 1'b0;
    end else begin
      o_update_done <= i_out_req; // one-cycle completion
      if (i_out_req) begin
        o_io_enable <= cmd_r[i_func_num][`FS_CMD_IO_BIT];
        o_mem_enable <= cmd_r[i_func_num][`FS_CMD_MEM_BIT];
        o_bus_master_enable <= cmd_r[i_func_num][`FS_CMD_BME_BIT];
        o_intx_disable <= cmd_r[i_func_num][`FS_CMD_INTDIS_BIT];
        o_serr_enable <= cmd_r[i_func_num][`FS_CMD_SERR_BIT];
        o_ecrc_gen_enable <= aer_r[i_func_num][`FS_AER_ECRC_GEN_BIT];
      end
    end
  end

  // receive filter: endpoint refuses disabled spaces, root passes all
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_accept <= 1'b0;
      o_rx_unsupported <= 1'b0;
    end else begin
      o_rx_accept <= 1'b0;
      o_rx_unsupported <= 1'b0;
      if (i_rx_valid) begin
        if (!IS_ENDPOINT) begin
          o_rx_accept <= 1'b1; // enables ignored here
        end else if ((i_rx_kind == RX_IO && !cmd_r[i_rx_func][`FS_CMD_IO_BIT]) ||
                     (i_rx_kind == RX_MEM && !cmd_r[i_rx_func][`FS_CMD_MEM_BIT])) begin
          o_rx_unsupported <= 1'b1;
        end else begin
          o_rx_accept <= 1'b1;
        end
      end
    end
  end

  // legacy interrupt blocked while the function inhibits it
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_intx_assert <= 1'b0;
    end else begin
      o_intx_assert <= i_intx_req && !cmd_r[i_intx_func][`FS_CMD_INTDIS_BIT];
    end
  end

endmodule

`default_nettype wire

/* verilog/func_status_defs.svh */
`ifndef FUNC_STATUS_DEFS_SVH
`define FUNC_STATUS_DEFS_SVH

// register address: function index in bits 4:2, register index in bits 1:0
`define FS_ADDR_W 5
`define FS_REG_CMD 2'h0
`define FS_REG_AER 2'h1
`define FS_REG_BRIDGE 2'h2
`define FS_REG_DEVSTS 2'h3

// reset values of the per-function registers
`define FS_CMD_RST 16'h0000
`define FS_AER_RST 16'h0000
`define FS_BRIDGE_RST 16'h0000
`define FS_DEVSTS_RST 1'b0

// command register field positions
`define FS_CMD_IO_BIT 0
`define FS_CMD_MEM_BIT 1
`define FS_CMD_BME_BIT 2
`define FS_CMD_SERR_BIT 8
`define FS_CMD_INTDIS_BIT 10

// other field positions
`define FS_BRIDGE_SERR_BIT 1
`define FS_AER_ECRC_GEN_BIT 6
`define FS_AER_ECRC_CHK_BIT 8
`define FS_DEVSTS_CORR_BIT 0

// status word slices for selector 0
`define FS_S0_IO 0
`define FS_S0_MEM 1
`define FS_S0_BME 2
`define FS_S0_INTDIS 3
`define FS_S0_SERR 4
`define FS_S0_BSERR 5
`define FS_S0_ECRC_CHK 6
`define FS_S0_ECRC_GEN 7
// status word slice for selector 1
`define FS_S1_CORR 0

`endif

/* verilog/func_status_pkg.sv */
`default_nettype none
package func_status_pkg;

  // status selector encodings; 6 and 7 are reserved
  typedef enum logic [2:0] {
    SEL_COMMAND = 3'h0,
    SEL_DEV_STATUS = 3'h1,
    SEL_2 = 3'h2,
    SEL_3 = 3'h3,
    SEL_4 = 3'h4,
    SEL_5 = 3'h5,
    SEL_RSVD6 = 3'h6,
    SEL_RSVD7 = 3'h7
  } status_sel_t;

  // kind of an incoming request seen by the receive filter
  typedef enum logic [0:0] {
    RX_IO = 1'b0,
    RX_MEM = 1'b1
  } rx_kind_t;

endpackage
`default_nettype wire

/* sim/fsq_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fsq_props (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire func_status_pkg::status_sel_t i_status_sel,
  input wire logic i_out_req,
  input wire logic [15:0] o_status_data,
  input wire logic o_update_done,
  input wire logic o_io_enable,
  input wire logic o_mem_enable,
  input wire logic o_bus_master_enable,
  input wire logic o_intx_disable,
  input wire logic o_serr_enable,
  input wire logic o_ecrc_gen_enable,
  input wire logic i_rx_valid,
  input wire logic o_rx_accept,
  input wire logic o_rx_unsupported,
  input wire logic i_intx_req,
  input wire logic o_intx_assert
);
  import func_status_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // completion tied to its request
  a_done_follows: assert property (i_out_req |=> o_update_done)
    else $error("no completion after request");
  a_done_cause: assert property (o_update_done |-> $past(i_out_req))
    else $error("completion without request");
  // selector 0 word against the per-function outputs
  a_sel0_cmd: assert property (o_update_done && $past(i_status_sel) == SEL_COMMAND |->
    o_status_data[3:0] == {o_intx_disable, o_bus_master_enable, o_mem_enable, o_io_enable})
    else $error("selector 0 low bits wrong");
  a_sel0_err: assert property (o_update_done && $past(i_status_sel) == SEL_COMMAND |->
    o_status_data[4] == o_serr_enable && o_status_data[7] == o_ecrc_gen_enable)
    else $error("selector 0 error bits wrong");
  a_sel0_upper: assert property (o_update_done && $past(i_status_sel) == SEL_COMMAND |->
    o_status_data[15:8] == 8'h00) else $error("selector 0 upper not zero");
  a_sel1_rest: assert property (o_update_done && $past(i_status_sel) == SEL_DEV_STATUS |->
    o_status_data[15:1] == 15'h0000) else $error("selector 1 upper not zero");
  a_rsvd_zero: assert property (o_update_done && $past(i_status_sel) > SEL_5 |->
    o_status_data == 16'h0000) else $error("reserved selector not zero");
  // word steady without request or selector change
  a_word_holds: assert property (!$past(i_out_req) && $past(i_status_sel) ==
    $past(i_status_sel, 2) |-> $stable(o_status_data)) else $error("word moved");
  a_rx_answer: assert property (i_rx_valid |=> o_rx_accept != o_rx_unsupported)
    else $error("receive request not answered once");
  a_intx_cause: assert property (o_intx_assert |-> $past(i_intx_req))
    else $error("interrupt without request");
  cover property (o_update_done && o_status_data != 16'h0000);
  cover property (o_rx_unsupported);
  cover property (o_intx_assert);
endmodule
bind func_status_query fsq_props u_props (.*);
`default_nettype wire

/* sim/fsq_requester.sv */
`include "func_status_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fsq_requester (
  input wire logic i_clk,
  input wire logic i_done,
  output var func_status_pkg::status_sel_t o_sel,
  output logic [2:0] o_func,
  output logic o_req
);
  import func_status_pkg::*;
  initial begin
    o_sel = SEL_COMMAND;
    o_func = 3'h0;
    o_req = 1'b0;
  end
  // one fetch; index and selector held until completion seen
  task automatic fetch(input status_sel_t s, input logic [2:0] f, output logic ok);
    @(posedge i_clk);
    o_sel <= s;
    o_func <= f;
    o_req <= 1'b1;
    @(posedge i_clk);
    o_req <= 1'b0;
    #1;
    for (int n = 0; n < 4 && i_done !== 1'b1; n++) @(posedge i_clk) #1;
    ok = (i_done === 1'b1);
  endtask
  // selector change alone, no fetch; the word follows for the latched function
  task automatic select(input status_sel_t s);
    @(posedge i_clk);
    o_sel <= s;
  endtask
  // whether user logic may send requests, judged from a selector 0 word
  function automatic logic may_issue(input logic [15:0] w, input bit root);
    if (root) begin
      return w[`FS_S0_MEM]; // root: bus master ignored, memory enable gates
    end
    return w[`FS_S0_BME]; // endpoint: requests only while bus master set
  endfunction
endmodule
`default_nettype wire

/* sim/tb_pcie_function_status_query.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pcie_function_status_query;
  import func_status_pkg::*;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, cev = 0, rxv = 0, ireq = 0;
  logic [4:0] addr = '0;
  logic [15:0] wdata = '0, c, a, b, v, rdat, sdat;
  logic [2:0] cfn = '0, rxf = '0, ifn = '0, fn;
  wire logic [5:0] pf;
  wire logic [1:0] rxo;
  logic req, done, ix, ok;
  rx_kind_t rxk = RX_IO;
  status_sel_t sel;
  int failures = 0, checks = 0;
  always #5 clk = ~clk;
  func_status_query DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
    .i_status_sel(sel), .i_func_num(fn), .i_out_req(req), .o_status_data(sdat),
    .o_update_done(done), .o_io_enable(pf[0]), .o_mem_enable(pf[1]),
    .o_bus_master_enable(pf[2]), .o_intx_disable(pf[3]), .o_serr_enable(pf[4]),
    .o_ecrc_gen_enable(pf[5]), .i_corr_err_evt(cev), .i_corr_err_func(cfn),
    .i_rx_valid(rxv), .i_rx_kind(rxk), .i_rx_func(rxf), .o_rx_accept(rxo[1]),
    .o_rx_unsupported(rxo[0]), .i_intx_req(ireq), .i_intx_func(ifn), .o_intx_assert(ix));
  fsq_requester u_req (.i_clk(clk), .i_done(done), .o_sel(sel), .o_func(fn), .o_req(req));
  // expected selector 0 word
  function automatic logic [15:0] s0w(input logic [15:0] c, a, b);
    return {8'h00, a[6], a[8], b[1], c[8], c[10], c[2:0]};
  endfunction
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [4:0] ad, input logic [15:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [4:0] ad);
    @(posedge clk);
    addr <= ad;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 v = rdat;
  endtask
  task automatic get(input status_sel_t s, input logic [2:0] f);
    u_req.fetch(s, f, ok);
    if (!ok) begin
      failures++;
      results();
    end
  endtask
  initial begin
    void'($urandom(28544));
    repeat (2) @(posedge clk);
    rst_b <= 1;
    for (int f = 0; f < 8; f++) begin
      c = (f == 0) ? 16'h0000 : (f == 7) ? 16'hffff : 16'($urandom);
      a = 16'($urandom);
      b = 16'($urandom);
      wreg({f[2:0], 2'h0}, c);
      wreg({f[2:0], 2'h1}, a);
      wreg({f[2:0], 2'h2}, b);
      rreg({f[2:0], 2'h0});
      chk("cmd", c, v);
      rreg({f[2:0], 2'h1});
      chk("aer", a, v);
      rreg({f[2:0], 2'h2});
      chk("bridge", b, v);
      get(SEL_COMMAND, f[2:0]);
      chk("word", s0w(c, a, b), sdat);
      chk("pf", {10'h000, a[6], c[8], c[10], c[2:0]}, {10'h000, pf});
      chk("issue", {15'h0000, u_req.may_issue(sdat, 1'b0)}, {15'h0000, pf[2]});
      chk("issue rp", {15'h0000, c[1]}, {15'h0000, u_req.may_issue(sdat, 1'b1)});
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        rxv <= 1;
        rxk <= rx_kind_t'(k);
        rxf <= f[2:0];
        @(posedge clk);
        rxv <= 0;
        #1 chk("rx", {14'h0000, c[k], !c[k]}, {14'h0000, rxo});
      end
      @(posedge clk);
      ireq <= 1;
      ifn <= f[2:0];
      repeat (2) @(posedge clk);
      #1 chk("intx", {15'h0000, !c[10]}, {15'h0000, ix});
      @(posedge clk);
      ireq <= 0;
      $display("test function %0d done", f);
    end
    get(SEL_COMMAND, 3'h7);
    repeat (3) @(posedge clk);
    #1 chk("hold", s0w(c, a, b), sdat);
    u_req.select(SEL_DEV_STATUS);
    repeat (2) @(posedge clk);
    #1 chk("sel refresh", 16'h0000, sdat);
    u_req.select(SEL_COMMAND);
    repeat (2) @(posedge clk);
    #1 chk("sel back", s0w(c, a, b), sdat);
    $display("test select done");
    @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    #1 chk("reset word", 16'h0000, sdat);
    chk("reset pf", 16'h0000, {10'h000, pf});
    get(SEL_COMMAND, 3'h7);
    chk("reset cmd", 16'h0000, sdat);
    $display("test reset done");
    @(posedge clk);
    cev <= 1;
    cfn <= 3'h5;
    @(posedge clk);
    cev <= 0;
    get(SEL_DEV_STATUS, 3'h5);
    chk("corr", 16'h0001, sdat);
    rreg(5'h17);
    chk("devsts", 16'h0001, v);
    wreg(5'h17, 16'h0001);
    get(SEL_DEV_STATUS, 3'h5);
    chk("corr clear", 16'h0000, sdat);
    for (int s = 2; s < 8; s++) begin
      get(status_sel_t'(s), 3'h1);
      chk("sel", 16'h0000, sdat);
    end
    $display("test selectors done");
    results();
  end
endmodule
`default_nettype wire
